// >>> sidr_consts.svh
`ifndef SIDR_CONSTS_SVH
`define SIDR_CONSTS_SVH
// printed offsets are register indices; byte address is four times the index
`define SIDR_IDX_VLAN_STS 16'h1810
`define SIDR_IDX_PT_CMD 16'h1811
`define SIDR_IDX_PT_WDATA 16'h1812
`define SIDR_IDX_PT_RDATA 16'h1813
`define SIDR_IDX_PT_STS 16'h1814
`define SIDR_IDX_GIC 16'h1840
`define SIDR_IDX_VLAN_CTL 16'h1880
`define SIDR_IDX_CNT_CTL 16'h1881
`define SIDR_ADDR_W 16
`define SIDR_CMD_DIR_BIT 7
`define SIDR_CMD_IDX_MSB 5
`define SIDR_PRIO_MSB 2
`define SIDR_GIC_WR_MASK 32'h00003FFC
`define SIDR_GIC_RESET 32'h00000004
`define SIDR_GIC_FIELDS_RESET 12'h001
`define SIDR_CNT_TEST_VALUE 32'h07FFFFFC
`define SIDR_VLAN_BUSY_CYCLES 4'h4
`define SIDR_TBL_DEPTH 64
`define SIDR_RESP_OKAY 2'h0
`define SIDR_RESP_SLVERR 2'h2
`endif

// >>> sidr_pkg.sv
`default_nettype none
package sidr_pkg;
   typedef enum logic [2:0] {
      SIDR_IDLE = 3'h1,
      SIDR_RUN = 3'h2,
      SIDR_DONE = 3'h4
   } sidr_tstate_t;

   // decoded global ingress controls presented to the switch engine
   typedef struct packed {
      logic snoop_echo;
      logic [2:0] snoop_ports;
      logic use_ip;
      logic mld_snoop;
      logic igmp_snoop;
      logic counter_test;
      logic da_priority;
      logic filter_mcast;
      logic drop_unknown;
      logic use_precedence;
   } sidr_ingress_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_held;
      logic w_held;
      logic [15:0] aw_idx;
      logic aw_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic cmd_dir;
      logic [5:0] cmd_idx;
      logic [2:0] wr_prio;
      logic [2:0] rd_prio;
      sidr_tstate_t tstate;
      logic vlan_pend;
      logic [3:0] vlan_cnt;
      sidr_ingress_t gic;
      logic [31:0] cnt_test_load;
      logic cnt_load_pulse;
   } sidr_state_t;
endpackage
`default_nettype wire

// >>> sidr_regs.sv
// What this block does
// - vlan status bit 0 is set during a vlan table command, self-clears.
// - a write to the command register launches one table access unless one is already running.
// - command bit 7 selects read (1) or write (0); resets to zero.
// - command bits 5:0 pick the table entry; bit 6 reserved.
// - each entry holds a three-bit receive priority in data bits 2:0.
// - table is not initialised at reset; host must fill it.
// - table status bit 0 is set while an access runs; resets zero.
// - ingress bit 13 allows snooped packets back to their source port.
// - ingress bits 12:10 are the snoop destination port bitmap.
// - ingress bit 9 admits the ip tos/sc field for queue choice.
// - ingress bit 8 enables ipv6 mld snooping to the snoop ports.
// - ingress bit 7 enables ipv4 igmp snooping to the snoop ports.
// - ingress bit 6 makes clear-on-read counters load 7FFF_FFCh instead.
// - ingress bit 5 takes queue from static lookup entry priority.
// - ingress bit 4 drops unknown multicast, broadcast exempt.
// - ingress bit 3 drops unknown unicast destinations.
// - ingress bit 2 picks tos precedence over the table; resets one.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sidr_consts.svh"
module sidr_regs (
   input wire logic sys_clk_i, // 100 MHz core clock
   input wire logic nrst_i, // async reset, active low
   input wire logic ce_i, // clock enable, freezes all state when low
   input wire logic [17:0] s_axi_awaddr_i, // write address, byte
   input wire logic s_axi_awvalid_i, // write address valid
   output logic s_axi_awready_o, // write address ready
   input wire logic [31:0] s_axi_wdata_i, // write data
   input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
   input wire logic s_axi_wvalid_i, // write data valid
   output logic s_axi_wready_o, // write data ready
   output logic [1:0] s_axi_bresp_o, // write response
   output logic s_axi_bvalid_o, // write response valid
   input wire logic s_axi_bready_i, // write response ready
   input wire logic [17:0] s_axi_araddr_i, // read address, byte
   input wire logic s_axi_arvalid_i, // read address valid
   output logic s_axi_arready_o, // read address ready
   output logic [31:0] s_axi_rdata_o, // read data
   output logic [1:0] s_axi_rresp_o, // read response
   output logic s_axi_rvalid_o, // read data valid
   input wire logic s_axi_rready_i, // read data ready
   input wire logic vlan_cmd_start_i, // one-cycle start of a vlan table command
   input wire logic counter_read_i, // engine reads a clear-on-read counter
   output var sidr_pkg::sidr_ingress_t ingress_o, // ingress controls to the engine
   output logic [31:0] counter_load_o, // value loaded after a counter read
   output logic counter_load_o_valid_o // one-cycle load strobe
);
   sidr_pkg::sidr_state_t q;
   sidr_pkg::sidr_state_t next_q;
   // table is a plain array with no reset, so its content is undefined until written
   logic [`SIDR_PRIO_MSB:0] prio_tbl [0:`SIDR_TBL_DEPTH-1];
   logic tbl_we;
   logic [`SIDR_PRIO_MSB:0] tbl_rd;

   function automatic logic [31:0] sidr_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic sidr_mapped(input logic [15:0] idx);
      logic hit;
      hit = 1'b0;
      // read-only registers count as mapped: writes to them answer okay and change nothing
      if (idx == `SIDR_IDX_VLAN_STS)
      begin
         hit = 1'b1;
      end
      else if (idx == `SIDR_IDX_PT_CMD)
      begin
         hit = 1'b1;
      end
      else if (idx == `SIDR_IDX_PT_WDATA)
      begin
         hit = 1'b1;
      end
      else if (idx == `SIDR_IDX_PT_RDATA)
      begin
         hit = 1'b1;
      end
      else if (idx == `SIDR_IDX_PT_STS)
      begin
         hit = 1'b1;
      end
      else if (idx == `SIDR_IDX_GIC)
      begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   always_comb
   begin
      logic [31:0] cur;
      logic [31:0] mrg;
      logic [15:0] ridx;
      logic do_wr;
      logic launch;
      cur = 32'h00000000;
      mrg = 32'h00000000;
      ridx = s_axi_araddr_i[17:2];
      do_wr = 1'b0;
      launch = 1'b0;
      next_q = q;
      tbl_we = 1'b0;
      next_q.cnt_load_pulse = 1'b0;

      // write channel: address and data may arrive in either order
      if (q.awready && s_axi_awvalid_i)
      begin
         next_q.awready = 1'b0;
         next_q.aw_held = 1'b1;
         next_q.aw_idx = s_axi_awaddr_i[17:2];
         next_q.aw_ok = (s_axi_awaddr_i[1:0] == 2'h0) && sidr_mapped(s_axi_awaddr_i[17:2]);
      end
      if (q.wready && s_axi_wvalid_i)
      begin
         next_q.wready = 1'b0;
         next_q.w_held = 1'b1;
         next_q.wdata = s_axi_wdata_i;
         next_q.wstrb = s_axi_wstrb_i;
      end
      // both halves held: the write lands and bvalid rises on the same edge
      if (q.aw_held && q.w_held && !q.bvalid)
      begin
         do_wr = q.aw_ok;
         next_q.aw_held = 1'b0;
         next_q.w_held = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp = q.aw_ok ? `SIDR_RESP_OKAY : `SIDR_RESP_SLVERR;
      end
      if (q.bvalid && s_axi_bready_i)
      begin
         next_q.bvalid = 1'b0;
         next_q.awready = 1'b1;
         next_q.wready = 1'b1;
      end

      if (do_wr)
      begin
         if (q.aw_idx == `SIDR_IDX_PT_CMD)
         begin
            cur = {24'h000000, q.cmd_dir, 1'b0, q.cmd_idx};
            mrg = sidr_merge(cur, q.wdata, q.wstrb);
            next_q.cmd_dir = mrg[`SIDR_CMD_DIR_BIT];
            next_q.cmd_idx = mrg[`SIDR_CMD_IDX_MSB:0];
            launch = 1'b1;
         end
         else if (q.aw_idx == `SIDR_IDX_PT_WDATA)
         begin
            mrg = sidr_merge({29'h00000000, q.wr_prio}, q.wdata, q.wstrb);
            next_q.wr_prio = mrg[`SIDR_PRIO_MSB:0];
         end
         else if (q.aw_idx == `SIDR_IDX_GIC)
         begin
            mrg = sidr_merge({18'h00000, q.gic, 2'h0}, q.wdata, q.wstrb) & `SIDR_GIC_WR_MASK;
            next_q.gic = mrg[13:2];
         end
      end

      // table access: one cycle to run, result captured the next
      // limitation: a command written mid-run starts nothing but still moves the index in use
      case (q.tstate)
         sidr_pkg::SIDR_IDLE:
         begin
            if (launch)
            begin
               next_q.tstate = sidr_pkg::SIDR_RUN;
            end
         end
         sidr_pkg::SIDR_RUN:
         begin
            tbl_we = !q.cmd_dir;
            next_q.tstate = sidr_pkg::SIDR_DONE;
         end
         sidr_pkg::SIDR_DONE:
         begin
            if (q.cmd_dir)
            begin
               next_q.rd_prio = tbl_rd;
            end
            next_q.tstate = sidr_pkg::SIDR_IDLE;
         end
         default:
         begin
            next_q.tstate = sidr_pkg::SIDR_IDLE;
         end
      endcase

      // vlan table engine busy window; start wins over completion
      if (vlan_cmd_start_i)
      begin
         next_q.vlan_pend = 1'b1;
         next_q.vlan_cnt = `SIDR_VLAN_BUSY_CYCLES;
      end
      else if (q.vlan_pend)
      begin
         next_q.vlan_cnt = q.vlan_cnt - 4'h1;
         if (q.vlan_cnt == 4'h1)
         begin
            next_q.vlan_pend = 1'b0;
         end
      end

      // counter test value replaces the usual clear-to-zero
      if (counter_read_i)
      begin
         next_q.cnt_load_pulse = 1'b1;
         next_q.cnt_test_load = q.gic.counter_test ? `SIDR_CNT_TEST_VALUE : 32'h00000000;
      end

      // read channel
      if (q.arready && s_axi_arvalid_i)
      begin
         next_q.arready = 1'b0;
         next_q.rvalid = 1'b1;
         next_q.rresp = `SIDR_RESP_OKAY;
         if (s_axi_araddr_i[1:0] != 2'h0)
         begin
            next_q.rresp = `SIDR_RESP_SLVERR;
            next_q.rdata = 32'h00000000;
         end
         else if (ridx == `SIDR_IDX_VLAN_STS)
         begin
            next_q.rdata = {31'h00000000, q.vlan_pend};
         end
         else if (ridx == `SIDR_IDX_PT_CMD)
         begin
            next_q.rdata = {24'h000000, q.cmd_dir, 1'b0, q.cmd_idx};
         end
         else if (ridx == `SIDR_IDX_PT_WDATA)
         begin
            next_q.rdata = {29'h00000000, q.wr_prio};
         end
         else if (ridx == `SIDR_IDX_PT_RDATA)
         begin
            next_q.rdata = {29'h00000000, q.rd_prio};
         end
         else if (ridx == `SIDR_IDX_PT_STS)
         begin
            // pending covers both the run and the capture cycle, so read data is settled once it drops
            next_q.rdata = {31'h00000000, (q.tstate != sidr_pkg::SIDR_IDLE)};
         end
         else if (ridx == `SIDR_IDX_GIC)
         begin
            next_q.rdata = {18'h00000, q.gic, 2'h0};
         end
         else
         begin
            next_q.rresp = `SIDR_RESP_SLVERR;
            next_q.rdata = 32'h00000000;
         end
      end
      if (q.rvalid && s_axi_rready_i)
      begin
         next_q.rvalid = 1'b0;
         next_q.arready = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         q <= '0;
         q.awready <= 1'b1;
         q.wready <= 1'b1;
         q.arready <= 1'b1;
         q.tstate <= sidr_pkg::SIDR_IDLE;
         q.gic <= `SIDR_GIC_FIELDS_RESET;
      end
      else if (ce_i)
      begin
         q <= next_q;
      end
   end

   // table array: no reset on purpose, so synthesis can map it to memory
   always_ff @(posedge sys_clk_i)
   begin
      if (ce_i && tbl_we)
         prio_tbl[q.cmd_idx] <= q.wr_prio;
   end
   assign tbl_rd = prio_tbl[q.cmd_idx];

   assign s_axi_awready_o = q.awready;
   assign s_axi_wready_o = q.wready;
   assign s_axi_bvalid_o = q.bvalid;
   assign s_axi_bresp_o = q.bresp;
   assign s_axi_arready_o = q.arready;
   assign s_axi_rvalid_o = q.rvalid;
   assign s_axi_rdata_o = q.rdata;
   assign s_axi_rresp_o = q.rresp;
   assign ingress_o = q.gic;
   assign counter_load_o = q.cnt_test_load;
   assign counter_load_o_valid_o = q.cnt_load_pulse;
endmodule
`default_nettype wire

// >>> sidr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sidr_consts.svh"
module sidr_regs_properties (
   input wire logic sys_clk_i, // clock
   input wire logic nrst_i, // reset
   input wire logic ce_i, // enable
   input wire logic s_axi_awvalid_i, // aw valid
   input wire logic s_axi_awready_o, // aw ready
   input wire logic s_axi_wvalid_i, // w valid
   input wire logic s_axi_wready_o, // w ready
   input wire logic s_axi_bvalid_o, // b valid
   input wire logic s_axi_bready_i, // b ready
   input wire logic s_axi_arvalid_i, // ar valid
   input wire logic s_axi_arready_o, // ar ready
   input wire logic s_axi_rvalid_o, // r valid
   input wire logic s_axi_rready_i, // r ready
   input wire logic [31:0] s_axi_rdata_o, // r data
   input wire logic counter_read_i, // counter read
   input wire sidr_pkg::sidr_ingress_t ingress_o, // ingress controls
   input wire logic [31:0] counter_load_o, // load value
   input wire logic counter_load_o_valid_o // load strobe
);
// frozen clock enable would stretch every latency, so it disables checking
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!nrst_i || !ce_i);
sequence aw_w_taken;
   s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
endsequence
sequence ar_taken;
   s_axi_arvalid_i && s_axi_arready_o;
endsequence
a_write_answer: assert property (aw_w_taken |-> ##2 s_axi_bvalid_o)
   else $error("write response late");
a_read_answer: assert property (ar_taken |=> s_axi_rvalid_o)
   else $error("read data late");
a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
   else $error("write response dropped");
a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
   else $error("read data not held");
a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
   else $error("second read accepted");
a_load_pulse: assert property (counter_read_i |=> counter_load_o_valid_o &&
   counter_load_o == ($past(ingress_o.counter_test) ? `SIDR_CNT_TEST_VALUE : 32'h0))
   else $error("counter load wrong");
a_load_cause: assert property (counter_load_o_valid_o |-> $past(counter_read_i))
   else $error("stray counter load");
a_config_write: assert property ($changed(ingress_o) |-> s_axi_bvalid_o && !$past(s_axi_bvalid_o))
   else $error("ingress changed without write");
a_write_closes: assert property (s_axi_bvalid_o && s_axi_bready_i |=> s_axi_awready_o && s_axi_wready_o && !s_axi_bvalid_o)
   else $error("write channel not reopened");
a_read_closes: assert property (s_axi_rvalid_o && s_axi_rready_i |=> s_axi_arready_o && !s_axi_rvalid_o)
   else $error("read channel not reopened");
a_write_ready_low: assert property (aw_w_taken |=> !s_axi_awready_o && !s_axi_wready_o)
   else $error("second write accepted");
endmodule
`default_nettype wire

// >>> sidr_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sidr_consts.svh"
module sidr_regs_bench;
logic sys_clk_i = 0, nrst_i = 0, ce_i = 1, vlan_cmd_start_i = 0, counter_read_i = 0;
logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
logic [17:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, counter_load_o, seed = 32'h2F, v, d;
logic [3:0] s_axi_wstrb_i = '0;
logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, counter_load_o_valid_o;
logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
sidr_pkg::sidr_ingress_t ingress_o;
logic [2:0] p [64];
logic [15:0] ix [6] = '{`SIDR_IDX_VLAN_STS, `SIDR_IDX_PT_CMD, `SIDR_IDX_PT_WDATA, `SIDR_IDX_PT_RDATA,
   `SIDR_IDX_PT_STS, `SIDR_IDX_GIC};
int mismatches = 0, compares = 0, cycles = 0, i;
sidr_regs uut (
   .sys_clk_i(sys_clk_i),
   .nrst_i(nrst_i),
   .ce_i(ce_i),
   .s_axi_awaddr_i(s_axi_awaddr_i),
   .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wdata_i(s_axi_wdata_i),
   .s_axi_wstrb_i(s_axi_wstrb_i),
   .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bresp_o(s_axi_bresp_o),
   .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i),
   .s_axi_araddr_i(s_axi_araddr_i),
   .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o),
   .s_axi_rresp_o(s_axi_rresp_o),
   .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i),
   .vlan_cmd_start_i(vlan_cmd_start_i),
   .counter_read_i(counter_read_i),
   .ingress_o(ingress_o),
   .counter_load_o(counter_load_o),
   .counter_load_o_valid_o(counter_load_o_valid_o)
);
always #5 sys_clk_i = ~sys_clk_i;
function automatic logic [31:0] rnd();
   seed = seed ^ (seed << 13);
   seed = seed ^ (seed >> 17);
   seed = seed ^ (seed << 5);
   return seed;
endfunction
function automatic logic [17:0] ba(input logic [15:0] x);
   return {x, 2'h0};
endfunction
task automatic conclude();
   $display("compares %0d mismatches %0d", compares, mismatches);
   if (mismatches == 0 && compares > 0)
      $display("bench passed");
   else
      $display("bench failed");
   $finish;
endtask
always @(posedge sys_clk_i)
begin
   cycles++;
   if (cycles == 20000)
   begin
      mismatches++;
      conclude();
   end
end
task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
   compares++;
   if (g !== e)
   begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
   end
endtask
// ready lines start low at random so the slave must hold its answer
task automatic wr(input logic [17:0] a, input logic [31:0] x, input logic [1:0] er);
   logic [31:0] r;
   logic done;
   r = rnd();
   done = 0;
   s_axi_awaddr_i <= a;
   s_axi_wdata_i <= x;
   s_axi_wstrb_i <= 4'hF;
   s_axi_awvalid_i <= 1'b1;
   s_axi_wvalid_i <= 1'b1;
   s_axi_bready_i <= r[0];
   while (!done)
   begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o)
         s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o)
         s_axi_wvalid_i <= 1'b0;
      done = s_axi_bvalid_o && s_axi_bready_i;
      if (s_axi_bvalid_o && !s_axi_bready_i)
         s_axi_bready_i <= 1'b1;
   end
   chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
endtask
task automatic rd(input logic [17:0] a, output logic [31:0] x, input logic [1:0] er);
   logic [31:0] r;
   logic done;
   r = rnd();
   done = 0;
   s_axi_araddr_i <= a;
   s_axi_arvalid_i <= 1'b1;
   s_axi_rready_i <= r[0];
   while (!done)
   begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o)
         s_axi_arvalid_i <= 1'b0;
      done = s_axi_rvalid_o && s_axi_rready_i;
      if (s_axi_rvalid_o && !s_axi_rready_i)
         s_axi_rready_i <= 1'b1;
   end
   x = s_axi_rdata_o;
   chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
endtask
task automatic poll(input logic [17:0] a);
   logic [31:0] x;
   int n;
   x = 1;
   n = 0;
   while (x[0] === 1'b1 && n < 20)
   begin
      rd(a, x, 2'h0);
      n++;
   end
   chk("pending", 32'h0, x);
endtask
task automatic count_read(input logic [31:0] e);
   int n;
   n = 0;
   counter_read_i <= 1'b1;
   @(posedge sys_clk_i);
   counter_read_i <= 1'b0;
   do
   begin
      @(posedge sys_clk_i);
      n++;
   end
   while (counter_load_o_valid_o !== 1'b1 && n < 5);
   chk("counter strobe", 32'h1, {31'h0, counter_load_o_valid_o});
   chk("counter load", e, counter_load_o);
endtask
initial
begin
   repeat (10) @(posedge sys_clk_i);
   nrst_i <= 1'b1;
   @(posedge sys_clk_i);
   for (i = 0; i < 6; i++)
   begin
      rd(ba(ix[i]), v, 2'h0);
      chk("reset value", i == 5 ? 32'h4 : 32'h0, v);
   end
   chk("ingress reset", 32'h1, {20'h0, ingress_o});
   rd(ba(16'h1900), v, 2'h2);
   chk("unmapped data", 32'h0, v);
   wr(ba(`SIDR_IDX_GIC) + 18'h1, 32'h0, 2'h2);
   wr(ba(`SIDR_IDX_PT_STS), 32'hFFFFFFFF, 2'h0);
   poll(ba(`SIDR_IDX_PT_STS));
   $display("test reset and refusals done");
   // host fills the whole table: it holds nothing after reset
   for (i = 0; i < 64; i++)
   begin
      d = rnd();
      p[i] = d[2:0];
      wr(ba(`SIDR_IDX_PT_WDATA), d, 2'h0);
      rd(ba(`SIDR_IDX_PT_WDATA), v, 2'h0);
      chk("write data", {29'h0, p[i]}, v);
      wr(ba(`SIDR_IDX_PT_CMD), {24'h0, 1'b0, d[6], i[5:0]}, 2'h0);
      poll(ba(`SIDR_IDX_PT_STS));
   end
   for (i = 63; i >= 0; i--)
   begin
      wr(ba(`SIDR_IDX_PT_CMD), {24'h0, 2'h3, i[5:0]}, 2'h0);
      rd(ba(`SIDR_IDX_PT_CMD), v, 2'h0);
      chk("command", {24'h0, 2'h2, i[5:0]}, v);
      poll(ba(`SIDR_IDX_PT_STS));
      rd(ba(`SIDR_IDX_PT_RDATA), v, 2'h0);
      chk("read data", {29'h0, p[i]}, v);
   end
   $display("test table done");
   for (i = 0; i < 12; i++)
   begin
      d = i == 0 ? 32'hFFFFFFFF : rnd();
      wr(ba(`SIDR_IDX_GIC), d, 2'h0);
      rd(ba(`SIDR_IDX_GIC), v, 2'h0);
      chk("config", d & 32'h3FFC, v);
      chk("ingress", {20'h0, d[13:2]}, {20'h0, ingress_o});
   end
   wr(ba(`SIDR_IDX_GIC), 32'h40, 2'h0);
   count_read(`SIDR_CNT_TEST_VALUE);
   wr(ba(`SIDR_IDX_GIC), 32'h0, 2'h0);
   count_read(32'h0);
   $display("test ingress done");
   vlan_cmd_start_i <= 1'b1;
   @(posedge sys_clk_i);
   vlan_cmd_start_i <= 1'b0;
   // enable held low longer than the busy window: pending must survive the freeze
   ce_i <= 1'b0;
   repeat (10) @(posedge sys_clk_i);
   ce_i <= 1'b1;
   rd(ba(`SIDR_IDX_VLAN_STS), v, 2'h0);
   chk("vlan pending", 32'h1, v);
   repeat (8) @(posedge sys_clk_i);
   rd(ba(`SIDR_IDX_VLAN_STS), v, 2'h0);
   chk("vlan done", 32'h0, v);
   nrst_i <= 1'b0;
   repeat (2) @(posedge sys_clk_i);
   nrst_i <= 1'b1;
   @(posedge sys_clk_i);
   rd(ba(`SIDR_IDX_GIC), v, 2'h0);
   chk("config after reset", 32'h4, v);
   $display("test vlan and reset done");
   conclude();
end
endmodule
bind sidr_regs sidr_regs_properties chk (.sys_clk_i, .nrst_i, .ce_i, .s_axi_awvalid_i, .s_axi_awready_o,
   .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
   .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .counter_read_i, .ingress_o, .counter_load_o,
   .counter_load_o_valid_o);
`default_nettype wire
